// ### design/ecl_ahb_regs.sv
/*
  AHB-Lite slave holding the loader command, reset, strap readback and
  ready registers. Assumes a single slave whose hreadyout is hready.
*/
`timescale 1ns/10ps
`default_nettype none
module ecl_ahb_regs
  import ecl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        loaderBusy,
  input  wire logic        overflowSet,
  input  wire logic [31:0] activeStraps,
  output logic             reloadPulse,
  output logic             digitalResetPulse,
  output logic             overflowFlag,
  output logic             readyFlag
);
  logic       wrPend;
  logic [7:0] wrOfs;

  wire addrPhase = hsel && hready && htrans[1] && (hsize == 3'b010);
  wire mapped    = (haddr[31:8] == 24'h000000);
  wire wrCmd     = wrPend && (wrOfs == ECL_OFS_CMD);
  wire wrRst     = wrPend && (wrOfs == ECL_OFS_RESET);
  wire ovfClear  = wrCmd && hwdata[ECL_CMD_OVF];

  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0000_0000;
    if (mapped) begin
      unique case (haddr[7:0])
        ECL_OFS_CMD: begin
          readMux[ECL_CMD_BUSY] = loaderBusy;
          readMux[ECL_CMD_OVF]  = overflowFlag;
        end
        ECL_OFS_STRAPS: readMux = activeStraps;
        ECL_OFS_HWCFG:  readMux[ECL_HWCFG_READY] = readyFlag;
        default:        readMux = 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign reloadPulse       = wrCmd && hwdata[ECL_CMD_RELOAD] && !loaderBusy;
  assign digitalResetPulse = wrRst && hwdata[ECL_RST_DIGITAL];
  assign readyFlag         = !loaderBusy;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend <= 1'b0;
      wrOfs  <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      wrPend <= addrPhase && hwrite && mapped;
      wrOfs  <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata <= readMux;
      end
    end
  end

  // a new overflow wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflowFlag <= 1'b0;
    end else begin
      overflowFlag <= overflowSet || (overflowFlag && !ovfClear);
    end
  end
endmodule : ecl_ahb_regs
`default_nettype wire

// ### design/ecl_loader.sv
/*
  Configuration loader: reads the serial configuration memory after
  reset or reload, overrides straps, synchronises strap-derived
  registers and replays register-write bursts. Assumes a byte reader
  that returns memRdByte with memRdValid while memRdReq is held, and a
  register write port acknowledged by wrAck, all on ref_clk.
*/
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ecl_loader
  import ecl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        pllLocked,
  input  wire logic [31:0] strapPins,
  input  wire logic [2:0]  memSizePins,
  output logic             memRdReq,
  output logic [15:0]      memRdAddr,
  input  wire logic [7:0]  memRdByte,
  input  wire logic        memRdValid,
  output logic             wrReq,
  output ecl_wr_t          wrCmd,
  input  wire logic        wrAck,
  input  wire logic        fabricCsrBusy,
  input  wire logic        phyMgmtBusy,
  output logic [31:0]      activeStraps,
  output logic             loaderBusy,
  output logic             readyFlag,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  ecl_state_t      state;
  ecl_phase_t      phase;
  logic [31:0]     strapMeta;
  logic [31:0]     strapSync;
  logic [2:0]      sizeMeta;
  logic [2:0]      sizeSync;
  logic [1:0]      pllMeta;
  logic [2:0]      sizeSel;
  logic [3:0][7:0] strapShadow;
  logic            strapOk;
  logic            syncContinue;
  logic [3:0]      syncIdx;
  logic [7:0]      burstsLeft;
  logic [7:0]      wordsLeft;
  logic [7:0]      wordAddr;
  logic [1:0]      byteIdx;
  logic [23:0]     dataShift;
  logic            overflowSet;
  logic            reloadPulse;
  logic            digitalResetPulse;

  // two-stage synchronisers for pin inputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      strapMeta <= 32'h0000_0000;
      strapSync <= 32'h0000_0000;
      sizeMeta  <= 3'h0;
      sizeSync  <= 3'h0;
      pllMeta   <= 2'h0;
    end else begin
      strapMeta <= strapPins;
      strapSync <= strapMeta;
      sizeMeta  <= memSizePins;
      sizeSync  <= sizeMeta;
      pllMeta   <= {pllMeta[0], pllLocked};
    end
  end

  ecl_ahb_regs u_regs (
    .ref_clk           (ref_clk),
    .arst_n            (arst_n),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hready),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .hrdata            (hrdata),
    .loaderBusy        (loaderBusy),
    .overflowSet       (overflowSet),
    .activeStraps      (activeStraps),
    .reloadPulse       (reloadPulse),
    .digitalResetPulse (digitalResetPulse),
    .overflowFlag      (),
    .readyFlag         (readyFlag)
  );

  wire        pllStable  = pllMeta[1];
  wire        startReq   = reloadPulse || digitalResetPulse;
  wire [15:0] sizeLimit  = ECL_SIZE_LIMIT[sizeSel];
  wire        overHit    = (state == ST_FETCH) && (memRdAddr > sizeLimit);
  wire        portsIdle  = !fabricCsrBusy && !phyMgmtBusy;
  wire        writing    = (state == ST_WRITE) || (state == ST_SYNC);
  wire        byteIn     = (state == ST_FETCH) && memRdValid && !overHit;
  wire        isMark     = (memRdByte == ECL_VALID_MARK);
  wire        lastBurst  = (burstsLeft == 8'h01);
  wire        lastWord   = (wordsLeft == 8'h01);
  wire        writeDone  = (state == ST_WRITE) && wrReq && wrAck;
  wire        syncDone   = (state == ST_SYNC) && wrReq && wrAck;

  assign memRdReq    = (state == ST_FETCH) && !overHit;
  assign wrReq       = writing && portsIdle;
  assign overflowSet = overHit;

  // strap-derived default for synchronisation step idx
  function automatic ecl_wr_t syncEntry(input logic [3:0] idx, input logic [31:0] s);
    ecl_wr_t    e;
    logic [7:0] p;
    logic [7:0] h;
    logic       an;
    logic       sp;
    logic       dp;
    logic       fc;
    logic [31:0] adv;
    logic [31:0] spec;
    logic [31:0] basic;
    e = '0;
    h = s[ECL_STRAP_HOST +: 8];
    p = (idx < 4'h3) ? s[ECL_STRAP_P1 +: 8] : s[ECL_STRAP_P2 +: 8];
    if (idx < 4'h6) begin
      an = p[ECL_SB_AUTONEG];
      sp = p[ECL_SB_SPEED];
      dp = p[ECL_SB_DUPLEX];
      fc = p[ECL_SB_FDFC];
    end else begin
      an = 1'b1;
      sp = h[ECL_SH_SPEED];
      dp = !h[ECL_SH_DUPPOL];
      fc = h[ECL_SH_FDFC];
    end
    adv  = ECL_ADV_BASE;
    adv[ECL_ADV_PAUSE] = fc;
    adv[8:5] = {sp && dp, sp, dp, 1'b1};
    spec = 32'h0000_0000;
    spec[ECL_SPEC_MODE +: 3] = {sp, dp, an};
    basic = 32'h0000_0000;
    basic[ECL_BASIC_SPEED]   = sp;
    basic[ECL_BASIC_AN_EN]   = an;
    basic[ECL_BASIC_DUPLEX]  = dp;
    basic[ECL_BASIC_RESTART] = 1'b1;
    unique case (idx)
      4'h0: e = '{ECL_REG_P1_ADV, adv};
      4'h1: e = '{ECL_REG_P1_SPECIAL, spec};
      4'h2: e = '{ECL_REG_P1_BASIC, basic};
      4'h3: e = '{ECL_REG_P2_ADV, adv};
      4'h4: e = '{ECL_REG_P2_SPECIAL, spec};
      4'h5: e = '{ECL_REG_P2_BASIC, basic};
      4'h6: e = '{ECL_REG_VLINK_ADV, adv};
      4'h7: e = '{ECL_REG_VLINK_SPEC, spec};
      4'h8: e = '{ECL_REG_VLINK_BASIC, basic};
      4'h9: e = '{ECL_REG_INDICATOR,
                  {22'h0, h[ECL_SH_LEDFUN +: 2], s[ECL_STRAP_LED +: 8]}};
      4'hA: e = '{ECL_REG_P1_PAUSE, {29'h0, s[ECL_STRAP_P1 + ECL_SB_BPEN],
                  s[ECL_STRAP_P1 + ECL_SB_FDFC], s[ECL_STRAP_P1 + ECL_SB_MANFC]}};
      4'hB: e = '{ECL_REG_P2_PAUSE, {29'h0, s[ECL_STRAP_P2 + ECL_SB_BPEN],
                  s[ECL_STRAP_P2 + ECL_SB_FDFC], s[ECL_STRAP_P2 + ECL_SB_MANFC]}};
      4'hC: e = '{ECL_REG_HOST_PAUSE, {29'h0, h[ECL_SH_BPEN], h[ECL_SH_FDFC],
                  h[ECL_SH_MANFC]}};
      default: e = '0;
    endcase
    return e;
  endfunction : syncEntry

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= ST_POWERUP;
      phase        <= PH_VALID;
      loaderBusy   <= 1'b1;
      activeStraps <= 32'h0000_0000;
      sizeSel      <= 3'h0;
      memRdAddr    <= 16'h0000;
      strapShadow  <= '0;
      strapOk      <= 1'b0;
      syncContinue <= 1'b0;
      syncIdx      <= 4'h0;
      burstsLeft   <= 8'h00;
      wordsLeft    <= 8'h00;
      wordAddr     <= 8'h00;
      byteIdx      <= 2'h0;
      dataShift    <= 24'h000000;
      wrCmd        <= '0;
    end else begin
      unique case (state)
        ST_POWERUP: begin
          activeStraps <= strapSync;
          sizeSel      <= sizeSync;
          if (pllStable) begin
            state <= ST_START;
          end
        end
        ST_WAIT: begin
          if (startReq) begin
            loaderBusy <= 1'b1;
            state      <= ST_START;
          end
        end
        ST_START: begin
          memRdAddr <= 16'h0000;
          phase     <= PH_VALID;
          syncIdx   <= 4'h0;
          state     <= ST_FETCH;
        end
        ST_FETCH: begin
          if (overHit) begin
            state <= ST_DONE;
          end else if (memRdValid) begin
            memRdAddr <= memRdAddr + 16'h0001;
            unique case (phase)
              PH_VALID: begin
                if (isMark) begin
                  phase <= PH_MAC;
                end else begin
                  syncContinue <= 1'b0;
                  state        <= ST_SYNC_LOAD;
                end
              end
              PH_MAC: begin
                if (memRdAddr == ECL_ADDR_LAST_MAC) begin
                  phase <= PH_STRAPFLAG;
                end
              end
              PH_STRAPFLAG: begin
                strapOk <= isMark;
                phase   <= PH_STRAP;
              end
              PH_STRAP: begin
                strapShadow[memRdAddr[1:0]] <= memRdByte;
                if (memRdAddr == ECL_ADDR_STRAP_LAST) begin
                  if (strapOk) begin
                    activeStraps <= {memRdByte, strapShadow[2],
                                     strapShadow[1], strapShadow[0]};
                  end
                  syncContinue <= 1'b1;
                  phase        <= PH_BURSTFLAG;
                  state        <= ST_SYNC_LOAD;
                end
              end
              PH_BURSTFLAG: begin
                if (isMark) begin
                  phase <= PH_NBURST;
                end else begin
                  state <= ST_DONE;
                end
              end
              PH_NBURST: begin
                burstsLeft <= memRdByte;
                if (memRdByte == 8'h00) begin
                  state <= ST_DONE;
                end else begin
                  phase <= PH_HDRHI;
                end
              end
              PH_HDRHI: begin
                wordAddr <= memRdByte;
                phase    <= PH_HDRLO;
              end
              PH_HDRLO: begin
                wordsLeft <= memRdByte;
                byteIdx   <= 2'h0;
                if (memRdByte != 8'h00) begin
                  phase <= PH_DATA;
                end else if (lastBurst) begin
                  state <= ST_DONE;
                end else begin
                  burstsLeft <= burstsLeft - 8'h01;
                  phase      <= PH_HDRHI;
                end
              end
              PH_DATA: begin
                byteIdx   <= byteIdx + 2'h1;
                dataShift <= {dataShift[15:0], memRdByte};
                if (byteIdx == 2'h3) begin
                  wrCmd <= '{{wordAddr, 2'b00}, {dataShift, memRdByte}};
                  state <= ST_WRITE;
                end
              end
              default: state <= ST_DONE;
            endcase
          end
        end
        ST_SYNC_LOAD: begin
          wrCmd <= syncEntry(syncIdx, activeStraps);
          state <= ST_SYNC;
        end
        ST_SYNC: begin
          if (syncDone) begin
            syncIdx <= syncIdx + 4'h1;
            if (syncIdx != ECL_SYNC_LAST) begin
              state <= ST_SYNC_LOAD;
            end else if (syncContinue) begin
              state <= ST_FETCH;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_WRITE: begin
          if (writeDone) begin
            wordAddr <= wordAddr + 8'h01;
            if (!lastWord) begin
              wordsLeft <= wordsLeft - 8'h01;
              state     <= ST_FETCH;
            end else if (lastBurst) begin
              state <= ST_DONE;
            end else begin
              burstsLeft <= burstsLeft - 8'h01;
              phase      <= PH_HDRHI;
              state      <= ST_FETCH;
            end
          end
        end
        ST_DONE: begin
          loaderBusy <= 1'b0;
          state      <= ST_WAIT;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_busy_on_start: assert property ((state == ST_WAIT) && startReq |=> loaderBusy)
    else $error("loader busy not set on start");
  a_ready_while_busy: assert property (loaderBusy |-> !readyFlag)
    else $error("ready shown while loader busy");
  a_write_ports_idle: assert property (wrReq |-> !fabricCsrBusy && !phyMgmtBusy)
    else $error("register write while a port is busy");
  a_restart_set: assert property (wrReq && (wrCmd.addr == ECL_REG_VLINK_BASIC)
    |-> wrCmd.data[ECL_BASIC_RESTART])
    else $error("basic register written without restart");
  a_no_overread: assert property (memRdReq |-> memRdAddr <= sizeLimit)
    else $error("memory read beyond size limit");
  a_overflow_stops: assert property (overHit |=> (state == ST_DONE) ##1 !loaderBusy)
    else $error("overflow did not end the run");
  a_done_clears: assert property ((state == ST_DONE) |=> !loaderBusy && (state == ST_WAIT))
    else $error("loader did not finish into wait");
  a_word_order: assert property (byteIn && (phase == PH_DATA) && (byteIdx == 2'h3)
    |=> (wrCmd.data == {$past(dataShift), $past(memRdByte)})
        && (wrCmd.addr == {$past(wordAddr), 2'b00}))
    else $error("burst word assembled in wrong order");
  a_addr_step: assert property (writeDone |=> wordAddr == $past(wordAddr) + 8'h01)
    else $error("burst address did not advance by one word");
  a_bad_burst_flag: assert property (byteIn && (phase == PH_BURSTFLAG) && !isMark
    |=> (state == ST_DONE) ##1 !loaderBusy)
    else $error("invalid burst flag did not end the run");
  a_bad_valid_sync: assert property (byteIn && (phase == PH_VALID) && !isMark
    |=> (state == ST_SYNC_LOAD) && !syncContinue)
    else $error("invalid memory did not fall back to strap sync");
endmodule : ecl_loader
`default_nettype wire

// ### design/ecl_pkg.sv
/*
  Constants, field layouts and types shared by the configuration loader
  and its register slave. Assumes byte addresses into the serial
  configuration memory and a 10-bit directly writable register space.
*/
package ecl_pkg;
  // memory image layout
  localparam logic [7:0]  ECL_VALID_MARK      = 8'hA5;
  localparam logic [15:0] ECL_ADDR_LAST_MAC   = 16'h0006;
  localparam logic [15:0] ECL_ADDR_STRAP_LAST = 16'h000B;
  // register slave offsets and bits
  localparam logic [7:0]  ECL_OFS_CMD     = 8'h00;
  localparam logic [7:0]  ECL_OFS_RESET   = 8'h04;
  localparam logic [7:0]  ECL_OFS_STRAPS  = 8'h08;
  localparam logic [7:0]  ECL_OFS_HWCFG   = 8'h0C;
  localparam int          ECL_CMD_BUSY    = 31;
  localparam int          ECL_CMD_RELOAD  = 30;
  localparam int          ECL_CMD_OVF     = 9;
  localparam int          ECL_RST_DIGITAL = 0;
  localparam int          ECL_HWCFG_READY = 0;
  // strap word: port 1, port 2, host port, indicator enables
  localparam int          ECL_STRAP_P1   = 0;
  localparam int          ECL_STRAP_P2   = 8;
  localparam int          ECL_STRAP_HOST = 16;
  localparam int          ECL_STRAP_LED  = 24;
  localparam int          ECL_SB_AUTONEG = 0;
  localparam int          ECL_SB_DUPLEX  = 1;
  localparam int          ECL_SB_SPEED   = 2;
  localparam int          ECL_SB_MANFC   = 5;
  localparam int          ECL_SB_FDFC    = 6;
  localparam int          ECL_SB_BPEN    = 7;
  localparam int          ECL_SH_DUPPOL  = 1;
  localparam int          ECL_SH_SPEED   = 2;
  localparam int          ECL_SH_MANFC   = 3;
  localparam int          ECL_SH_FDFC    = 4;
  localparam int          ECL_SH_BPEN    = 5;
  localparam int          ECL_SH_LEDFUN  = 6;
  // synchronised register addresses (byte addresses)
  localparam logic [9:0]  ECL_REG_P1_ADV      = 10'h100;
  localparam logic [9:0]  ECL_REG_P1_SPECIAL  = 10'h104;
  localparam logic [9:0]  ECL_REG_P1_BASIC    = 10'h108;
  localparam logic [9:0]  ECL_REG_P2_ADV      = 10'h110;
  localparam logic [9:0]  ECL_REG_P2_SPECIAL  = 10'h114;
  localparam logic [9:0]  ECL_REG_P2_BASIC    = 10'h118;
  localparam logic [9:0]  ECL_REG_VLINK_ADV   = 10'h1C0;
  localparam logic [9:0]  ECL_REG_VLINK_SPEC  = 10'h1C4;
  localparam logic [9:0]  ECL_REG_VLINK_BASIC = 10'h1C8;
  localparam logic [9:0]  ECL_REG_INDICATOR   = 10'h1D0;
  localparam logic [9:0]  ECL_REG_P1_PAUSE    = 10'h1A0;
  localparam logic [9:0]  ECL_REG_P2_PAUSE    = 10'h1A4;
  localparam logic [9:0]  ECL_REG_HOST_PAUSE  = 10'h1A8;
  localparam logic [3:0]  ECL_SYNC_LAST       = 4'hC;
  // field positions inside the synchronised registers
  localparam int          ECL_BASIC_SPEED   = 13;
  localparam int          ECL_BASIC_AN_EN   = 12;
  localparam int          ECL_BASIC_RESTART = 9;
  localparam int          ECL_BASIC_DUPLEX  = 8;
  localparam int          ECL_ADV_PAUSE     = 10;
  localparam logic [31:0] ECL_ADV_BASE      = 32'h0000_0001;
  localparam int          ECL_SPEC_MODE     = 5;
  localparam int          ECL_IND_FUN       = 8;
  // largest address of each memory size range, by size strap
  localparam logic [7:0][15:0] ECL_SIZE_LIMIT = {
    16'hFFFF, 16'h7FFF, 16'h3FFF, 16'h1FFF,
    16'h07FF, 16'h01FF, 16'h00FF, 16'h007F};

  typedef struct packed {
    logic [9:0]  addr;
    logic [31:0] data;
  } ecl_wr_t;

  typedef enum logic [2:0] {
    ST_POWERUP   = 3'b000,
    ST_WAIT      = 3'b001,
    ST_START     = 3'b010,
    ST_FETCH     = 3'b011,
    ST_SYNC_LOAD = 3'b100,
    ST_SYNC      = 3'b101,
    ST_WRITE     = 3'b110,
    ST_DONE      = 3'b111
  } ecl_state_t;

  typedef enum logic [3:0] {
    PH_VALID     = 4'b0000,
    PH_MAC       = 4'b0001,
    PH_STRAPFLAG = 4'b0010,
    PH_STRAP     = 4'b0011,
    PH_BURSTFLAG = 4'b0100,
    PH_NBURST    = 4'b0101,
    PH_HDRHI     = 4'b0110,
    PH_HDRLO     = 4'b0111,
    PH_DATA      = 4'b1000
  } ecl_phase_t;
endpackage : ecl_pkg

// ### verif/ecl_mem_model.sv
/* serial configuration memory model holding a byte image.
   assumes requests held until memRdValid; slow adds two cycles of lag. */
`timescale 1ns/10ps
`default_nettype none
module ecl_mem_model
  import ecl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic        memRdReq,
  input  wire logic [15:0] memRdAddr,
  output logic             memRdValid,
  output logic [7:0]       memRdByte
);
  logic [7:0] image [256];
  logic [1:0] lag = 2'h0;
  wire        due = memRdReq && !memRdValid && lag == {slow, 1'b0};
  initial memRdValid = 1'b0;
  initial memRdByte = 8'h00;
  always @(posedge ref_clk) begin
    lag        <= (memRdReq && !memRdValid && !due) ? lag + 2'h1 : 2'h0;
    memRdValid <= due;
    // released data line toggles so a stale byte never looks valid
    memRdByte  <= due ? image[memRdAddr[7:0]] : ~memRdByte;
  end
endmodule : ecl_mem_model
`default_nettype wire

// ### verif/eeprom_config_loader_bursts_bench.sv
/* bench for the loader: power-up load with bursts, reload, digital reset, overflow.
   assumes ecl_loader and ecl_mem_model; the bench acks register writes. */
`timescale 1ns/10ps
`default_nettype none
module eeprom_config_loader_bursts_bench;
  import ecl_pkg::*;
  logic        ref_clk = 0, arst_n = 0, pllLocked = 0, slow = 0, wrAck = 0;
  logic        csrBusy = 0, pmBusy = 0, hsel = 0, hwrite = 0;
  logic        memRdReq, memRdValid, wrReq, loaderBusy, readyFlag, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  memSize = 3'h7;
  logic [3:0]  cyc = 4'h0;
  logic [7:0]  memRdByte;
  logic [15:0] memRdAddr;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, activeStraps, rd;
  logic [31:0] strapPins = 32'h8421_C3A5;
  ecl_wr_t     wrCmd, wrLog[$];
  ecl_wr_t     burst[3] = '{{10'h040, 32'h1011_1213}, {10'h080, 32'h1617_1819},
                            {10'h084, 32'h1A1B_1C1D}};
  int          num_errors = 0, check_count = 0;
  always #50 ref_clk = ~ref_clk;
  ecl_loader dut (.ref_clk(ref_clk), .arst_n(arst_n), .pllLocked(pllLocked),
    .strapPins(strapPins), .memSizePins(memSize), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
    .memRdByte(memRdByte), .memRdValid(memRdValid), .wrReq(wrReq), .wrCmd(wrCmd),
    .wrAck(wrAck), .fabricCsrBusy(csrBusy), .phyMgmtBusy(pmBusy), .activeStraps(activeStraps),
    .loaderBusy(loaderBusy), .readyFlag(readyFlag), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  ecl_mem_model mem (.ref_clk(ref_clk), .slow(slow), .memRdReq(memRdReq),
    .memRdAddr(memRdAddr), .memRdValid(memRdValid), .memRdByte(memRdByte));
  task automatic check(input logic [41:0] seen, input logic [41:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    check(42'(hresp), 42'h0);
  endtask : ahb
  task automatic waitIdle;
    repeat (6) @(posedge ref_clk);
    for (int n = 0; n < 6000 && loaderBusy !== 1'b0; n++) @(posedge ref_clk);
    if (loaderBusy !== 1'b0) num_errors++;
  endtask : waitIdle
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // busy inputs toggle throughout; no write may be requested while either is high
  always @(posedge ref_clk) begin
    cyc    <= cyc + 4'h1;
    csrBusy <= cyc[2];
    pmBusy <= (cyc == 4'h9);
    wrAck  <= wrReq && !wrAck;
    if (wrReq && wrAck) wrLog.push_back(wrCmd);
    if (csrBusy || pmBusy) check(42'(wrReq), 42'h0);
    if (arst_n) check(42'(readyFlag), 42'(!loaderBusy));
  end
  initial begin
    #5_000_000;
    num_errors++;
    end_of_test();
  end
  initial begin
    automatic int pokes[8][2] = '{'{0, 'hA5}, '{7, 'hA5}, '{12, 'hA5}, '{13, 2}, '{14, 'h10},
                        '{15, 1}, '{20, 'h20}, '{21, 2}};
    for (int i = 0; i < 256; i++) mem.image[i] = 8'(i);
    foreach (pokes[i]) mem.image[pokes[i][0]] = 8'(pokes[i][1]);
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    check(42'(memRdReq), 42'h0);
    pllLocked <= 1'b1;
    waitIdle();
    check(42'(wrLog.size()), 42'd16);
    check(42'(wrLog[6].addr), 42'(ECL_REG_VLINK_ADV));
    check(42'(wrLog[7].addr), 42'(ECL_REG_VLINK_SPEC));
    check(42'(wrLog[8].addr), 42'(ECL_REG_VLINK_BASIC));
    check(42'(wrLog[8].data[ECL_BASIC_RESTART]), 42'h1);
    check(42'(wrLog[8].data), 42'h0000_1200);
    check(42'(wrLog[9].addr), 42'(ECL_REG_INDICATOR));
    check(42'(wrLog[12].addr), 42'(ECL_REG_HOST_PAUSE));
    foreach (burst[i]) check(wrLog[13 + i], burst[i]);
    ahb(1'b0, 32'h8, 32'h0, rd);
    check(42'(rd), 42'h0B0A_0908);
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(42'(rd[ECL_CMD_BUSY]), 42'h0);
    // reload with slow memory and no burst flag
    wrLog.delete();
    mem.image[12] = 8'h5A;
    slow <= 1'b1;
    ahb(1'b1, 32'h0, 32'h4000_0000, rd);
    ahb(1'b0, 32'hC, 32'h0, rd);
    check(42'(rd[ECL_HWCFG_READY]), 42'h0);
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(42'(rd[ECL_CMD_BUSY]), 42'h1);
    waitIdle();
    check(42'(wrLog.size()), 42'd13);
    // digital reset with an invalid image
    wrLog.delete();
    mem.image[0] = 8'h00;
    ahb(1'b1, 32'h4, 32'h1, rd);
    waitIdle();
    check(42'(wrLog.size()), 42'd13);
    check(42'(wrLog[8].data[ECL_BASIC_RESTART]), 42'h1);
    // smallest memory size with endless bursts runs past the limit
    mem.image[0] = 8'hA5;
    mem.image[7] = 8'h00;
    mem.image[12] = 8'hA5;
    mem.image[13] = 8'hFF;
    arst_n <= 1'b0;
    memSize <= 3'h0;
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    waitIdle();
    check(42'(loaderBusy), 42'h0);
    check(42'(memRdAddr), 42'h80);
    check(42'(activeStraps), 42'(strapPins));
    ahb(1'b0, 32'h0, 32'h0, rd);
    check(42'(rd[ECL_CMD_OVF]), 42'h1);
    ahb(1'b0, 32'h8, 32'h0, rd);
    check(42'(rd), 42'(strapPins));
    end_of_test();
  end
endmodule : eeprom_config_loader_bursts_bench
`default_nettype wire
